// File: rtl/csm_status_mode.sv
`timescale 1ns/1ps
// Contract
// - compat bit 1 selects legacy mode
// - bit 14, reset 0, page-relative direct
// - bit 14 set: stack-relative direct
// - I/O direct always peripheral-page relative
// - bit 6 shifts multiply result left
// - hold request tri-states port; bit 12
// - hold-stop bit 1 stalls internal execution
// - bit 11 resets 1, blocks maskable
// - nonmaskable never blocked by disable
// - soft interrupt and reset set disable
// - update in execute; no interrupt after
// - interrupt entry pushes status word
// - service entry sets disable bit
// - vector call leaves disable unchanged
// - return restores disable from stack
// - emulation halt: only time-critical and nonmaskable interrupts
// - bit 10, reset 0, width select
// - set/clear instructions change mode bits
// - width 0 sign 31, 1 sign 39
// - compat bit 5, reset 1
module csm_status_mode
    import csm_pkg::*;
(
    input  wire logic                        clk_sys,
    input  wire logic                        rst_n,
    input  wire logic                        clk_en,
    // Execute-phase update port
    input  wire csm_pkg::csm_op_t            exec_op,
    input  wire logic [csm_pkg::BITSEL_W-1:0] exec_bit,
    input  wire logic [csm_pkg::REG_W-1:0]   exec_wdata,
    input  wire logic                        soft_int_exec,
    input  wire logic                        soft_reset_exec,
    input  wire logic                        vector_call_exec,
    input  wire logic                        hw_int_entry,
    input  wire logic                        reti_exec,
    input  wire logic [csm_pkg::REG_W-1:0]   reti_stack_data,
    output logic [csm_pkg::REG_W-1:0]        status_rdata,
    output logic                             push_valid,
    output logic [csm_pkg::REG_W-1:0]        push_data,
    // Interrupt gating
    input  wire logic                        maskable_req,
    input  wire logic                        nonmask_req,
    input  wire logic                        time_critical_req,
    input  wire logic                        emu_halt,
    output logic                             int_take,
    // Addressing and datapath steering
    input  wire logic [csm_pkg::ADDR_W-1:0]  dir_offset,
    input  wire logic [csm_pkg::ADDR_W-1:0]  data_page_pointer,
    input  wire logic [csm_pkg::ADDR_W-1:0]  data_stack_pointer,
    input  wire logic [csm_pkg::IO_ADDR_W-1:0] peripheral_page_pointer,
    output logic [csm_pkg::ADDR_W-1:0]       dir_data_addr,
    output logic [csm_pkg::IO_ADDR_W-1:0]    dir_io_addr,
    input  wire logic [31:0]                 mult_raw,
    output logic [32:0]                      mult_result,
    output logic [5:0]                       acc_sign_pos,
    // Hold handling
    input  wire logic                        hold_req,
    output logic                             ext_port_oe,
    output logic                             exec_stall,
    // Mode outputs
    output logic                             legacy_compat_mode,
    output logic                             stack_relative_direct,
    output logic                             fractional_shift_mode,
    output logic                             hold_stop_mode,
    output logic                             global_int_disable,
    output logic                             wide_accum_mode
);
    import csm_pkg::*;

    // ----------------------------------------
    // Reset release through two flip-flops
    // ----------------------------------------
    logic [SYNC_STAGES-1:0] rst_pipe_reg;
    logic [SYNC_STAGES-1:0] rst_pipe_next;
    logic                   rst_sync_n;

    // Shift in a one after release
    always_comb begin
        rst_pipe_next = {rst_pipe_reg[SYNC_STAGES-2:0], 1'b1};
    end

    // Asynchronous assert, synchronous release
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe_reg <= '0;
        end else begin
            rst_pipe_reg <= rst_pipe_next;
        end
    end

    assign rst_sync_n = rst_pipe_reg[SYNC_STAGES-1];

    // ----------------------------------------
    // Mode bit register
    // ----------------------------------------
    csm_update_if upd ();

    csm_mode_bits u_bits (
        .clk_sys    (clk_sys),
        .rst_sync_n (rst_sync_n),
        .clk_en     (clk_en),
        .upd        (upd)
    );

    logic [15:0] cur;
    logic        entry_any;
    assign cur       = upd.cur_val;
    assign entry_any = soft_int_exec | soft_reset_exec | hw_int_entry;

    // Compute the execute-phase update; entry wins on the disable bit only
    always_comb begin
        upd.next_val = cur;
        upd.load     = 1'b0;
        unique case (exec_op)
            CSM_OP_SET: begin
                upd.next_val = cur | (16'h0001 << exec_bit);
                upd.load     = 1'b1;
            end
            CSM_OP_CLEAR: begin
                upd.next_val = cur & ~(16'h0001 << exec_bit);
                upd.load     = 1'b1;
            end
            CSM_OP_WRITE: begin
                upd.next_val = exec_wdata;
                upd.load     = 1'b1;
            end
            CSM_OP_NONE: begin
            end
        endcase
        if (reti_exec) begin
            upd.next_val = reti_stack_data;
            upd.load     = 1'b1;
        end
        if (entry_any) begin
            upd.next_val[BIT_GID] = 1'b1;
            upd.load              = 1'b1;
        end
        // Vector call has no path into the register
    end

    assign status_rdata = cur;

    // ----------------------------------------
    // Status push on interrupt entry
    // ----------------------------------------
    logic        push_valid_reg;
    logic        push_valid_next;
    logic [15:0] push_data_reg;
    logic [15:0] push_data_next;

    // Capture pre-entry status word
    always_comb begin
        push_valid_next = entry_any;
        push_data_next  = entry_any ? cur : push_data_reg;
    end

    // Register the push
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            push_valid_reg <= 1'b0;
            push_data_reg  <= '0;
        end else if (clk_en) begin
            push_valid_reg <= push_valid_next;
            push_data_reg  <= push_data_next;
        end
    end

    assign push_valid = push_valid_reg;
    assign push_data  = push_data_reg;

    // ----------------------------------------
    // Mode decode
    // ----------------------------------------
    // Values act from the cycle after the update
    assign legacy_compat_mode    = cur[BIT_COMPAT];
    assign stack_relative_direct = cur[BIT_STACK_DIR];
    assign fractional_shift_mode = cur[BIT_FRACT];
    assign hold_stop_mode        = cur[BIT_HOLD_STOP];
    assign global_int_disable    = cur[BIT_GID];
    assign wide_accum_mode       = cur[BIT_WIDE];

    // Interrupt gating; set bit blocks the same cycle it shows
    always_comb begin
        if (emu_halt) begin
            int_take = time_critical_req | nonmask_req;
        end else begin
            int_take = nonmask_req
                     | (maskable_req & ~cur[BIT_GID]);
        end
    end

    // Direct addressing base select
    always_comb begin
        if (cur[BIT_STACK_DIR]) begin
            dir_data_addr = data_stack_pointer + dir_offset;
        end else begin
            dir_data_addr = data_page_pointer + dir_offset;
        end
        dir_io_addr = peripheral_page_pointer + dir_offset[IO_ADDR_W-1:0];
    end

    // Fractional shift and accumulator sign position
    always_comb begin
        mult_result  = cur[BIT_FRACT] ? {mult_raw, 1'b0} : {1'b0, mult_raw};
        acc_sign_pos = cur[BIT_WIDE] ? 6'(ACC_SIGN_WIDE) : 6'(ACC_SIGN_NARROW);
    end

    // Hold: port released always, stall only in stop mode
    always_comb begin
        ext_port_oe = ~hold_req;
        exec_stall  = hold_req & cur[BIT_HOLD_STOP];
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_set_gid;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (clk_en && entry_any) |=> global_int_disable;
    endproperty
    a_set_gid: assert property (p_set_gid) else $error("disable not set on entry");

    property p_nmi;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        nonmask_req |-> int_take;
    endproperty
    a_nmi: assert property (p_nmi) else $error("nonmaskable blocked");

    property p_mask;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (global_int_disable && !emu_halt && !nonmask_req) |-> !int_take;
    endproperty
    a_mask: assert property (p_mask) else $error("maskable taken while disabled");

    property p_push;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (clk_en && entry_any) |=> (push_valid && push_data == $past(status_rdata));
    endproperty
    a_push: assert property (p_push) else $error("status not pushed");

    property p_reti;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (clk_en && reti_exec && !entry_any) |=>
            global_int_disable == $past(reti_stack_data[BIT_GID]);
    endproperty
    a_reti: assert property (p_reti) else $error("return did not restore");

    property p_vcall;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (clk_en && vector_call_exec && exec_op == CSM_OP_NONE && !reti_exec && !entry_any)
            |=> $stable(global_int_disable);
    endproperty
    a_vcall: assert property (p_vcall) else $error("vector call changed disable");

    property p_hold;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        hold_req |-> (!ext_port_oe && exec_stall == hold_stop_mode);
    endproperty
    a_hold: assert property (p_hold) else $error("hold handling wrong");

    property p_setbit;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (clk_en && exec_op == CSM_OP_SET && exec_bit == 4'(BIT_WIDE) && !reti_exec) |=> wide_accum_mode;
    endproperty
    a_setbit: assert property (p_setbit) else $error("set instruction ignored");

    property p_dir;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        stack_relative_direct |-> dir_data_addr == data_stack_pointer + dir_offset;
    endproperty
    a_dir: assert property (p_dir) else $error("direct base wrong");

    property p_page;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        !stack_relative_direct |-> dir_data_addr == data_page_pointer + dir_offset;
    endproperty
    a_page: assert property (p_page) else $error("page base wrong");

    property p_clrbit;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (clk_en && exec_op == CSM_OP_CLEAR && exec_bit == 4'(BIT_FRACT) && !reti_exec) |=> !fractional_shift_mode;
    endproperty
    a_clrbit: assert property (p_clrbit) else $error("clear instruction ignored");

    property p_no_take;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (clk_en && exec_op == CSM_OP_SET && exec_bit == 4'(BIT_GID) && !reti_exec)
            |=> (!int_take || nonmask_req || emu_halt);
    endproperty
    a_no_take: assert property (p_no_take) else $error("interrupt taken after disable set");

    property p_fract;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        fractional_shift_mode |-> (mult_result[0] == 1'b0 && mult_result[32:1] == mult_raw);
    endproperty
    a_fract: assert property (p_fract) else $error("fractional shift wrong");

    property p_width;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        wide_accum_mode |-> acc_sign_pos == 6'(ACC_SIGN_WIDE);
    endproperty
    a_width: assert property (p_width) else $error("wide sign position wrong");
endmodule : csm_status_mode

// File: rtl/csm_pkg.sv
package csm_pkg;
    // ----------------------------------------
    // Register layout
    // ----------------------------------------
    localparam int unsigned  REG_W          = 16;
    localparam int unsigned  BIT_COMPAT     = 5;
    localparam int unsigned  BIT_FRACT      = 6;
    localparam int unsigned  BIT_WIDE       = 10;
    localparam int unsigned  BIT_GID        = 11;
    localparam int unsigned  BIT_HOLD_STOP  = 12;
    localparam int unsigned  BIT_STACK_DIR  = 14;
    localparam logic [15:0]  MODE_MASK      = 16'h5C60;
    localparam logic [15:0]  RESET_VALUE    = 16'h0820;
    // ----------------------------------------
    // Bit-operation codes and address widths
    // ----------------------------------------
    localparam int unsigned  BITSEL_W       = 4;
    localparam int unsigned  ADDR_W         = 24;
    localparam int unsigned  IO_ADDR_W      = 16;
    localparam int unsigned  ACC_SIGN_NARROW = 31;
    localparam int unsigned  ACC_SIGN_WIDE   = 39;
    localparam int unsigned  SYNC_STAGES    = 2;
    typedef enum logic [1:0] {
        CSM_OP_NONE  = 2'b00,
        CSM_OP_SET   = 2'b01,
        CSM_OP_CLEAR = 2'b10,
        CSM_OP_WRITE = 2'b11
    } csm_op_t;
endpackage : csm_pkg

// File: rtl/csm_update_if.sv
`timescale 1ns/1ps
// Carries the pending update from the main block to the bit register
interface csm_update_if;
    logic [15:0] next_val;
    logic        load;
    logic [15:0] cur_val;
    modport ctrl (output next_val, output load, input cur_val);
    modport bits (input next_val, input load, output cur_val);
endinterface : csm_update_if

// File: rtl/csm_mode_bits.sv
`timescale 1ns/1ps
// Holds the mode bits with their reset values
module csm_mode_bits
    import csm_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst_sync_n,
    input  wire logic clk_en,
    csm_update_if.bits upd
);
    logic [15:0] mode_reg;
    logic [15:0] mode_next;

    // Next value, only mode field bits kept
    always_comb begin
        mode_next = mode_reg;
        if (upd.load) begin
            mode_next = upd.next_val & MODE_MASK;
        end
    end

    // Register stage
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mode_reg <= RESET_VALUE;
        end else if (clk_en) begin
            mode_reg <= mode_next;
        end
    end

    assign upd.cur_val = mode_reg;
endmodule : csm_mode_bits

// File: verif/csm_status_mode_tb.sv
`timescale 1ns/1ps
module csm_status_mode_tb;
    import csm_pkg::*;
    logic         clk_sys, rst_n, clk_en, soft_int_exec, soft_reset_exec, vector_call_exec, hw_int_entry;
    logic         reti_exec, push_valid, maskable_req, nonmask_req, time_critical_req, emu_halt, int_take;
    logic         hold_req, ext_port_oe, exec_stall, legacy_compat_mode, stack_relative_direct;
    logic         fractional_shift_mode, hold_stop_mode, global_int_disable, wide_accum_mode;
    csm_op_t      exec_op;
    logic [3:0]   exec_bit;
    logic [15:0]  exec_wdata, reti_stack_data, status_rdata, push_data, peripheral_page_pointer, dir_io_addr;
    logic [23:0]  dir_offset, data_page_pointer, data_stack_pointer, dir_data_addr;
    logic [31:0]  mult_raw;
    logic [32:0]  mult_result;
    logic [5:0]   acc_sign_pos;
    int           miscompares, n_checks;
    logic [15:0]  exp_st;

    csm_status_mode csm_status_mode_inst (.*);

    // ----------------------------------------
    // Clock and helpers
    // ----------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic chk(logic [39:0] got, logic [39:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic step();
        @(negedge clk_sys);
    endtask : step

    // Register value and all six mode outputs
    task automatic chk_st(logic [15:0] e);
        chk(status_rdata, e);
        chk({stack_relative_direct, hold_stop_mode, global_int_disable, wide_accum_mode, fractional_shift_mode,
             legacy_compat_mode}, {e[14], e[12], e[11], e[10], e[6], e[5]});
    endtask : chk_st

    task automatic do_op(csm_op_t op, logic [3:0] b, logic [15:0] d);
        exec_op = op;
        exec_bit = b;
        exec_wdata = d;
        step();
        exec_op = CSM_OP_NONE;
        step();
    endtask : do_op

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        rst_n = 1'b0;
        repeat (2) step();
        chk_st(16'h0820);
        rst_n = 1'b1;
        repeat (3) step();
        chk_st(16'h0820);
    endtask : t_reset

    // Set then clear every index; non-mode indices must be dropped
    task automatic t_setclr();
        exp_st = 16'h0820;
        // No repeat loop runs here, so compat may change
        for (int b = 0; b < 16; b++) begin
            do_op(CSM_OP_SET, b[3:0], 16'h0000);
            exp_st = exp_st | (MODE_MASK & (16'h0001 << b));
            chk_st(exp_st);
        end
        for (int b = 0; b < 16; b++) begin
            do_op(CSM_OP_CLEAR, b[3:0], 16'h0000);
            exp_st = exp_st & ~(16'h0001 << b);
            chk_st(exp_st);
        end
        clk_en = 1'b0;
        do_op(CSM_OP_SET, 4'hA, 16'h0000);
        chk_st(16'h0000);
        clk_en = 1'b1;
    endtask : t_setclr

    // Steering outputs in both settings of every mode
    task automatic t_steer();
        do_op(CSM_OP_WRITE, 4'h0, 16'hFFFF);
        chk_st(MODE_MASK);
        chk(dir_data_addr, 24'h020123);
        chk(dir_io_addr, 16'h4123);
        chk(mult_result, 33'h100000002);
        chk(acc_sign_pos, 6'h27);
        hold_req = 1'b1;
        step();
        chk(ext_port_oe, 1'b0);
        chk(exec_stall, 1'b1);
        do_op(CSM_OP_WRITE, 4'h0, 16'h0000);
        chk(ext_port_oe, 1'b0);
        chk(exec_stall, 1'b0);
        chk(dir_data_addr, 24'h010123);
        chk(dir_io_addr, 16'h4123);
        chk(mult_result, 33'h080000001);
        chk(acc_sign_pos, 6'h1F);
        hold_req = 1'b0;
        step();
        chk(ext_port_oe, 1'b1);
    endtask : t_steer

    // Maskable, nonmaskable and emulation-halt gating
    task automatic t_gate();
        do_op(CSM_OP_SET, 4'hB, 16'h0000);
        maskable_req = 1'b1;
        step();
        chk(int_take, 1'b0);
        nonmask_req = 1'b1;
        step();
        chk(int_take, 1'b1);
        nonmask_req = 1'b0;
        do_op(CSM_OP_CLEAR, 4'hB, 16'h0000);
        chk(int_take, 1'b1);
        emu_halt = 1'b1;
        step();
        chk(int_take, 1'b0);
        time_critical_req = 1'b1;
        step();
        chk(int_take, 1'b1);
        {emu_halt, time_critical_req} = 2'b00;
    endtask : t_gate

    // Service entries, vector call and return
    task automatic t_entry();
        for (int k = 0; k < 3; k++) begin
            do_op(CSM_OP_WRITE, 4'h0, 16'h0420);
            {soft_int_exec, soft_reset_exec, hw_int_entry} = 3'b100 >> k;
            exec_op = CSM_OP_CLEAR;
            exec_bit = 4'hB;
            step();
            {soft_int_exec, soft_reset_exec, hw_int_entry} = 3'b000;
            exec_op = CSM_OP_NONE;
            chk_st(16'h0C20);
            chk({push_valid, push_data}, {1'b1, 16'h0420});
            chk(int_take, 1'b0);
            step();
            chk(push_valid, 1'b0);
        end
        do_op(CSM_OP_WRITE, 4'h0, 16'h0420);
        vector_call_exec = 1'b1;
        step();
        vector_call_exec = 1'b0;
        chk_st(16'h0420);
        chk(push_valid, 1'b0);
        reti_exec = 1'b1;
        reti_stack_data = 16'hFFFF;
        do_op(CSM_OP_WRITE, 4'h0, 16'h0000);
        reti_exec = 1'b0;
        chk_st(MODE_MASK);
        maskable_req = 1'b0;
    endtask : t_entry

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {clk_en, soft_int_exec, soft_reset_exec, vector_call_exec, hw_int_entry} = 5'h10;
        {reti_exec, maskable_req, nonmask_req, time_critical_req, emu_halt, hold_req} = 6'h00;
        exec_op = CSM_OP_NONE;
        exec_bit = 4'h0;
        exec_wdata = 16'h0000;
        reti_stack_data = 16'h0000;
        dir_offset = 24'h000123;
        data_page_pointer = 24'h010000;
        data_stack_pointer = 24'h020000;
        peripheral_page_pointer = 16'h4000;
        mult_raw = 32'h80000001;
        miscompares = 0;
        n_checks = 0;
        t_reset();
        t_setclr();
        t_steer();
        t_gate();
        t_entry();
        t_reset();
        final_report();
    end
endmodule : csm_status_mode_tb
